// ### src/ddrmc_cal_timer.sv
// calibration gap timer and automatic calibration requester
`timescale 1ns/1ps
module ddrmc_cal_timer
    import ddrmc_pkg::*;
#(
    parameter int UNIT = CAL_GAP_UNIT
)(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    // control
    input  wire logic [7:0] gap,
    input  wire logic       auto_off,
    input  wire logic       idle,
    input  wire logic       cal_done,
    // request
    ddrmc_req_if.src        rq
);
    localparam int PW = $clog2(UNIT + 1);
    logic [PW-1:0] pre_r;
    logic [7:0]    units_r;
    logic          ripe;

    // ============================================================
    // gap counter, restarts after every calibration
    assign ripe = (units_r >= gap);
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || cal_done)
        begin
            pre_r   <= '0;
            units_r <= '0;
        end
        else if (!ripe)
        begin
            if (pre_r == PW'(UNIT - 1))
            begin
                pre_r   <= '0;
                units_r <= units_r + 8'h01;
            end
            else
                pre_r <= pre_r + PW'(1);
        end
    end

    // ask only when enabled, idle and the gap has passed
    assign rq.req = ripe && !auto_off && idle;
endmodule

// ### src/ddrmc_maint_ctrl.sv
// maintenance command controller: mode register writes, calibration, refresh
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module ddrmc_maint_ctrl
    import ddrmc_pkg::*;
#(
    parameter int REF_INTERVAL = 390
)(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    // controller state
    input  wire logic        ctrl_idle,
    // dram command port
    output logic             dram_cmd_valid,
    output ddrmc_cmd_t       dram_cmd,
    output logic      [1:0]  dram_bank,
    output logic      [15:0] dram_addr,
    input  wire logic        dram_cmd_ready
);
    // ============================================================
    // registers
    logic [1:0]  mr_target_r;
    logic [15:0] mr_payload_r;
    logic        mr_busy_r;
    logic        cal_off_r;
    logic        cal_req_r;
    logic        ref_req_r;
    logic        ref_off_r;
    logic [7:0]  cal_gap_r;
    logic        mr_strobe;
    logic        mr_take;
    logic        wr_ctrl;
    logic        wr_gap;
    logic        wr_mr;

    assign wr_ctrl   = reg_wr && (reg_addr == CAL_REF_CTRL_OFS);
    assign wr_gap    = reg_wr && (reg_addr == CAL_INTERVAL_OFS);
    assign wr_mr     = reg_wr && (reg_addr == MODE_REG_CMD_OFS);
    assign mr_strobe = wr_mr && reg_wdata[MR_STROBE_BIT];
    assign mr_take   = mr_strobe && !mr_busy_r;

    // ============================================================
    // command selection, one issue per accepted cycle
    ddrmc_cmd_t sel;
    logic       issue;
    logic       auto_cal_req;
    logic       auto_cal_grant;
    logic [REF_PEND_W-1:0] ref_pend_r;
    logic       ref_auto_req;
    logic       flush_r;

    ddrmc_req_if cal_if ();

    ddrmc_cal_timer u_cal_timer (
        .ref_clk  (ref_clk),
        .rst_n    (rst_n),
        .gap      (cal_gap_r),
        .auto_off (cal_off_r),
        .idle     (ctrl_idle),
        .cal_done (auto_cal_grant),
        .rq       (cal_if.src)
    );
    assign auto_cal_req = cal_if.req;

    assign ref_auto_req = (ref_pend_r != '0) && (!ref_off_r || flush_r);

    // priority: mode register, manual refresh, pending refresh, calibration
    always_comb
    begin
        sel = DDRMC_CMD_NONE;
        if (mr_busy_r)
            sel = DDRMC_CMD_MRS;
        else if (ref_req_r || ref_auto_req)
            sel = DDRMC_CMD_REFRESH;
        else if (cal_req_r || auto_cal_req)
            sel = DDRMC_CMD_DLL_CAL;
    end
    assign issue          = (sel != DDRMC_CMD_NONE) && dram_cmd_ready;
    assign dram_cmd_valid = (sel != DDRMC_CMD_NONE);
    assign dram_cmd       = sel;
    assign dram_bank      = mr_target_r;
    assign dram_addr      = mr_payload_r;
    assign auto_cal_grant = issue && (sel == DDRMC_CMD_DLL_CAL);
    assign cal_if.grant   = auto_cal_grant;

    // ============================================================
    // mode register fields, frozen while a write is pending
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            mr_target_r  <= MR_TARGET_RST;
            mr_payload_r <= MR_PAYLOAD_RST;
        end
        else if (wr_mr && !mr_busy_r)
        begin
            mr_target_r  <= reg_wdata[MR_TARGET_LSB +: 2];
            mr_payload_r <= reg_wdata[15:0];
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            mr_busy_r <= 1'b0;
        else if (mr_take)
            mr_busy_r <= 1'b1;
        else if (issue && sel == DDRMC_CMD_MRS)
            mr_busy_r <= 1'b0;
    end

    // ============================================================
    // control bits
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            cal_off_r <= 1'b0;
            ref_off_r <= 1'b0;
            cal_gap_r <= CAL_GAP_RST;
        end
        else
        begin
            if (wr_ctrl)
            begin
                cal_off_r <= reg_wdata[CAL_OFF_BIT];
                ref_off_r <= reg_wdata[REF_OFF_BIT];
            end
            if (wr_gap)
                cal_gap_r <= reg_wdata[7:0];
        end
    end

    // self clearing requests: a new write wins over the clear
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            cal_req_r <= 1'b0;
        else if (wr_ctrl && reg_wdata[CAL_REQ_BIT])
            cal_req_r <= 1'b1;
        else if (issue && sel == DDRMC_CMD_DLL_CAL)
            cal_req_r <= 1'b0;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            ref_req_r <= 1'b0;
        else if (wr_ctrl && reg_wdata[REF_REQ_BIT])
            ref_req_r <= 1'b1;
        else if (issue && sel == DDRMC_CMD_REFRESH && ref_req_r)
            ref_req_r <= 1'b0;
    end

    // ============================================================
    // automatic refresh: interval timer builds a pending count
    localparam int RW = $clog2(REF_INTERVAL + 1);
    logic [RW-1:0] ref_tmr_r;
    logic          ref_tick;
    logic          ref_served;

    assign ref_tick   = (ref_tmr_r == RW'(REF_INTERVAL - 1));
    assign ref_served = issue && sel == DDRMC_CMD_REFRESH && !ref_req_r;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_n || ref_tick)
            ref_tmr_r <= '0;
        else
            ref_tmr_r <= ref_tmr_r + RW'(1);
    end

    // no new debt while disabled; saturates rather than wraps
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            ref_pend_r <= '0;
        else if (ref_tick && !ref_off_r && !ref_served && ref_pend_r != '1)
            ref_pend_r <= ref_pend_r + REF_PEND_W'(1);
        else if (ref_served && !(ref_tick && !ref_off_r))
            ref_pend_r <= ref_pend_r - REF_PEND_W'(1);
    end

    // disable edge: drain whatever was owed at that moment
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            flush_r <= 1'b0;
        else if (wr_ctrl && reg_wdata[REF_OFF_BIT] && !ref_off_r)
            flush_r <= 1'b1;
        else if (ref_pend_r == '0 || !ref_off_r)
            flush_r <= 1'b0;
    end

    // ============================================================
    // read data, one cycle after the strobe
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
            reg_rdata <= 32'h00000000;
        else if (reg_rd)
        begin
            reg_rdata <= 32'h00000000;
            case (reg_addr)
                MODE_REG_CMD_OFS:
                begin
                    reg_rdata[MR_BUSY_BIT]         <= mr_busy_r;
                    reg_rdata[MR_TARGET_LSB +: 2]  <= mr_target_r;
                    reg_rdata[15:0]                <= mr_payload_r;
                end
                CAL_REF_CTRL_OFS:
                begin
                    reg_rdata[CAL_OFF_BIT] <= cal_off_r;
                    reg_rdata[CAL_REQ_BIT] <= cal_req_r;
                    reg_rdata[REF_REQ_BIT] <= ref_req_r;
                    reg_rdata[REF_OFF_BIT] <= ref_off_r;
                end
                CAL_INTERVAL_OFS:
                    reg_rdata[7:0] <= cal_gap_r;
                default:
                    reg_rdata <= 32'h00000000;
            endcase
        end
        else
            reg_rdata <= 32'h00000000;
    end
endmodule

// ### src/ddrmc_pkg.sv
// constants shared by the maintenance command block
// ============================================================
package ddrmc_pkg;
    // ============================================================
    // register map
    localparam logic [7:0]  CAL_REF_CTRL_OFS  = 8'h58;
    localparam logic [7:0]  CAL_INTERVAL_OFS  = 8'h5C;
    localparam logic [7:0]  MODE_REG_CMD_OFS  = 8'h54;
    // ============================================================
    // field positions
    localparam int          MR_BUSY_BIT       = 31;
    localparam int          MR_TARGET_LSB     = 20;
    localparam int          MR_STROBE_BIT     = 16;
    localparam int          CAL_OFF_BIT       = 5;
    localparam int          CAL_REQ_BIT       = 4;
    localparam int          REF_REQ_BIT       = 1;
    localparam int          REF_OFF_BIT       = 0;
    // ============================================================
    // reset values and counts
    localparam logic [1:0]  MR_TARGET_RST     = 2'h0;
    localparam logic [15:0] MR_PAYLOAD_RST    = 16'h0000;
    localparam logic [7:0]  CAL_GAP_RST       = 8'h00;
    localparam int          CAL_GAP_UNIT      = 1024;
    localparam int          REF_PEND_W        = 4;

    typedef enum logic [2:0] {
        DDRMC_CMD_NONE,
        DDRMC_CMD_MRS,
        DDRMC_CMD_REFRESH,
        DDRMC_CMD_DLL_CAL
    } ddrmc_cmd_t;
endpackage

// ### src/ddrmc_req_if.sv
// request and grant bundle between arbiter and sources
`timescale 1ns/1ps
interface ddrmc_req_if;
    logic req;
    logic grant;
    modport src (output req, input grant);
    modport arb (input req, output grant);
endinterface

// ### test/ddrmc_dram_model.sv
// dram command taker with a stall input
`timescale 1ns/1ps
module ddrmc_dram_model
    import ddrmc_pkg::*;
(
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    // command port
    input  wire logic        dram_cmd_valid,
    input  wire ddrmc_cmd_t  dram_cmd,
    input  wire logic [1:0]  dram_bank,
    input  wire logic [15:0] dram_addr,
    output logic             dram_cmd_ready,
    // bench control and tallies
    input  wire logic        hold,
    output int               n_ref,
    output int               n_cal,
    output logic      [17:0] last_mrs
);
    // held device takes nothing, so refresh debt can build up
    assign dram_cmd_ready = !hold;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            n_ref <= 0;
            n_cal <= 0;
            last_mrs <= 18'h0;
        end
        else if (dram_cmd_valid && !hold)
        begin
            if (dram_cmd == DDRMC_CMD_REFRESH)
                n_ref <= n_ref + 1;
            if (dram_cmd == DDRMC_CMD_DLL_CAL)
                n_cal <= n_cal + 1;
            if (dram_cmd == DDRMC_CMD_MRS)
                last_mrs <= {dram_bank, dram_addr};
        end
    end
endmodule

// ### test/ddrmc_maint_ctrl_assertions.sv
// port checker for the maintenance command controller
`timescale 1ns/1ps
module ddrmc_maint_ctrl_assertions
    import ddrmc_pkg::*;
#(
    parameter int REF_INTERVAL = 390
)(
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        rst_n,
    // register port
    input wire logic [7:0]  reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [31:0] reg_rdata,
    // controller and dram side
    input wire logic        ctrl_idle,
    input wire logic        dram_cmd_valid,
    input wire ddrmc_cmd_t  dram_cmd,
    input wire logic [1:0]  dram_bank,
    input wire logic [15:0] dram_addr,
    input wire logic        dram_cmd_ready
);
    // ============================================================
    // helper state
    logic        mrs_on, cal_on, ref_on, w54, w58, cal_req_r, cal_off_r;
    logic [7:0]  gap_r;
    logic [19:0] since_r;
    assign mrs_on = dram_cmd_valid && dram_cmd == DDRMC_CMD_MRS;
    assign cal_on = dram_cmd_valid && dram_cmd == DDRMC_CMD_DLL_CAL;
    assign ref_on = dram_cmd_valid && dram_cmd == DDRMC_CMD_REFRESH;
    assign w54 = reg_wr && reg_addr == MODE_REG_CMD_OFS;
    assign w58 = reg_wr && reg_addr == CAL_REF_CTRL_OFS;
    always_ff @(posedge ref_clk)
    begin
        if (!rst_n)
        begin
            cal_req_r <= 1'b0;
            cal_off_r <= 1'b0;
            gap_r <= 8'h00;
            since_r <= 20'hFFFFF;
        end
        else
        begin
            if (w58)
                cal_off_r <= reg_wdata[CAL_OFF_BIT];
            if (w58 && reg_wdata[CAL_REQ_BIT])
                cal_req_r <= 1'b1;
            else if (cal_on && dram_cmd_ready)
                cal_req_r <= 1'b0;
            if (reg_wr && reg_addr == CAL_INTERVAL_OFS)
                gap_r <= reg_wdata[7:0];
            // first automatic calibration after reset is free
            if (cal_on && dram_cmd_ready && !cal_req_r)
                since_r <= 20'h0;
            else if (since_r != 20'hFFFFF)
                since_r <= since_r + 20'h1;
        end
    end
    // ============================================================
    // properties
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    a_mrs_accept: assert property (w54 && reg_wdata[MR_STROBE_BIT] && !mrs_on |=> mrs_on
        && dram_bank == $past(reg_wdata[21:20]) && dram_addr == $past(reg_wdata[15:0]))
        else $error("mode write not offered");
    a_mrs_hold: assert property (mrs_on && !dram_cmd_ready |=> mrs_on && $stable(dram_addr))
        else $error("mode write dropped early");
    a_mrs_drop: assert property (mrs_on && dram_cmd_ready |=> !mrs_on)
        else $error("mode write repeated");
    a_busy_refuse: assert property (mrs_on && w54 |=> $stable(dram_bank) && $stable(dram_addr))
        else $error("busy write not ignored");
    a_cal_idle: assert property ($rose(cal_on) && !cal_req_r |-> ctrl_idle || $past(ctrl_idle))
        else $error("auto calibration while busy");
    a_cal_off: assert property (cal_off_r && $past(cal_off_r, 2) && !cal_req_r |-> !cal_on)
        else $error("auto calibration while off");
    a_cal_gap: assert property (cal_on && dram_cmd_ready && !cal_req_r
        |-> since_r + 20'h8 >= gap_r * CAL_GAP_UNIT)
        else $error("calibration gap too short");
    a_ref_manual: assert property (w58 && reg_wdata[REF_REQ_BIT]
        |-> ##[1:40] (ref_on && dram_cmd_ready))
        else $error("manual refresh missing");
    a_cal_manual: assert property (w58 && reg_wdata[CAL_REQ_BIT]
        |-> ##[1:40] (cal_on && dram_cmd_ready))
        else $error("manual calibration missing");
    c_mrs: cover property (mrs_on && dram_cmd_ready);
    c_ref: cover property (ref_on && dram_cmd_ready);
    c_cal: cover property (cal_on && dram_cmd_ready && !cal_req_r);
endmodule
bind ddrmc_maint_ctrl ddrmc_maint_ctrl_assertions #(.REF_INTERVAL(REF_INTERVAL)) chk_inst (.*);

// ### test/ddrmc_maint_ctrl_tb.sv
// self-checking bench for the maintenance command controller
`timescale 1ns/1ps
module ddrmc_maint_ctrl_tb
    import ddrmc_pkg::*;
;
    logic        ref_clk, rst_n, reg_wr, reg_rd, ctrl_idle, hold, dram_cmd_valid, dram_cmd_ready;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata, v;
    ddrmc_cmd_t  dram_cmd;
    logic [1:0]  dram_bank;
    logic [15:0] dram_addr;
    logic [17:0] last_mrs;
    int          n_ref, n_cal, n0, fail_count, cmp_count;
    // short refresh interval keeps the run brief
    ddrmc_maint_ctrl #(.REF_INTERVAL(20)) ddrmc_maint_ctrl_inst (.ref_clk, .rst_n, .reg_addr,
        .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ctrl_idle, .dram_cmd_valid, .dram_cmd,
        .dram_bank, .dram_addr, .dram_cmd_ready);
    ddrmc_dram_model ddrmc_dram_model_inst (.ref_clk, .rst_n, .dram_cmd_valid, .dram_cmd,
        .dram_bank, .dram_addr, .dram_cmd_ready, .hold, .n_ref, .n_cal, .last_mrs);
    // ============================================================
    // tasks
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e)
        begin
            fail_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task automatic mrs_wait;
        v = 32'hFFFFFFFF;
        for (int i = 0; i < 50 && v[MR_BUSY_BIT]; i++)
            rd(MODE_REG_CMD_OFS, v);
        chk(v[MR_BUSY_BIT], 1'b0);
    endtask
    task automatic final_report;
        if (fail_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // ============================================================
    // clock, watchdog, tests
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        fail_count++;
        final_report();
    end
    initial
    begin
        {reg_wr, reg_rd, ctrl_idle, hold, rst_n} = 5'h0;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        fail_count = 0;
        cmp_count = 0;
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(MODE_REG_CMD_OFS, v);
        chk(v, 32'h0);
        wr(8'h60, 32'hFF);
        rd(8'h60, v);
        chk(v, 32'h0);
        rd(CAL_INTERVAL_OFS, v);
        chk(v, 32'h0);
        wr(CAL_REF_CTRL_OFS, 32'h21);
        for (int t = 0; t < 4; t++)
        begin
            wr(MODE_REG_CMD_OFS, {10'h0, t[1:0], 3'h0, 1'b1, 12'hA5C, t[3:0]});
            mrs_wait();
            chk(last_mrs, {t[1:0], 12'hA5C, t[3:0]});
            rd(MODE_REG_CMD_OFS, v);
            chk(v, {10'h0, t[1:0], 4'h0, 12'hA5C, t[3:0]});
        end
        // second write lands while the first is still pending
        hold <= 1'b1;
        wr(MODE_REG_CMD_OFS, 32'h00311234);
        wr(MODE_REG_CMD_OFS, 32'h0001BEEF);
        rd(MODE_REG_CMD_OFS, v);
        chk(v, 32'h80301234);
        hold <= 1'b0;
        mrs_wait();
        chk(last_mrs, {2'h3, 16'h1234});
        for (int k = 0; k < 2; k++)
        begin
            n0 = k ? n_cal : n_ref;
            wr(CAL_REF_CTRL_OFS, k ? 32'h31 : 32'h23);
            repeat (10) @(posedge ref_clk);
            chk((k ? n_cal : n_ref) - n0, 1);
            rd(CAL_REF_CTRL_OFS, v);
            chk(v, 32'h21);
        end
        ctrl_idle <= 1'b1;
        n0 = n_ref + n_cal;
        repeat (100) @(posedge ref_clk);
        chk(n_ref + n_cal - n0, 0);
        ctrl_idle <= 1'b0;
        hold <= 1'b1;
        wr(CAL_REF_CTRL_OFS, 32'h20);
        repeat (70) @(posedge ref_clk);
        n0 = n_ref;
        wr(CAL_REF_CTRL_OFS, 32'h21);
        hold <= 1'b0;
        repeat (20) @(posedge ref_clk);
        chk(n_ref - n0 >= 3, 1);
        n0 = n_ref;
        repeat (60) @(posedge ref_clk);
        chk(n_ref - n0, 0);
        // gap still zero: timer is ripe, so only the idle gate holds calibration back
        wr(CAL_REF_CTRL_OFS, 32'h01);
        n0 = n_cal;
        repeat (50) @(posedge ref_clk);
        chk(n_cal - n0, 0);
        wr(CAL_INTERVAL_OFS, 32'h1);
        rd(CAL_INTERVAL_OFS, v);
        chk(v, 32'h1);
        ctrl_idle <= 1'b1;
        repeat (2600) @(posedge ref_clk);
        chk(n_cal - n0 >= 2 && n_cal - n0 <= 3, 1);
        final_report();
    end
endmodule
